// File: testbench/cfl_flag_unit_asserts.sv
// concurrent checks on the condition-flag unit's bus handshake and flag results
// assumes hready is tied to hreadyout and the checker is bound to cfl_flag_unit
`timescale 1ns/10ps
`default_nettype none
`include "cfl_defines.vh"

module cfl_flag_unit_chk (
    input wire logic        hclk,      // bus clock
    input wire logic        hresetn,   // async reset, active low
    input wire logic        hsel,      // slave select
    input wire logic [31:0] haddr,     // byte address
    input wire logic [1:0]  htrans,    // transfer type
    input wire logic        hwrite,    // write when high
    input wire logic [2:0]  hsize,     // transfer size
    input wire logic [31:0] hwdata,    // write data
    input wire logic        hready,    // bus ready in
    input wire logic        hreadyout, // slave ready
    input wire logic        hresp,     // response
    input wire logic [31:0] hrdata,    // read data
    input wire logic [7:0]  flags      // live flag byte
);
    logic       cmd_q;
    wire  logic taken;
    wire  [5:0] op;

    assign taken = hsel && htrans[1] && hready;
    assign op    = hwdata[5:0];

    // marks the data phase of a word write to the command register
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            cmd_q <= 1'b0;
        else
            cmd_q <= taken && hwrite && hsize == 3'h2 && haddr == 32'h10;
    end

    default clocking dc @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
    a_read_wait: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
    a_write_nowait: assert property (taken && hwrite |=> hreadyout) else $error("write stalled");
    a_and_flags: assert property (cmd_q && op == `CFL_OP_AND |=> flags[4] && !flags[1] && !flags[0])
        else $error("and flags wrong");
    a_sub_sets_n: assert property (cmd_q && (op == `CFL_OP_SUB || op == `CFL_OP_CMP || op == `CFL_OP_NEG)
        |=> flags[1]) else $error("subtract flag not set");
    a_add_clears_n: assert property (cmd_q && (op == `CFL_OP_ADD || op == `CFL_OP_ADC16) |=> !flags[1])
        else $error("subtract flag not cleared");
    a_carry_kept: assert property (cmd_q && (op == `CFL_OP_DGL || op == `CFL_OP_BIT || op == `CFL_OP_INC
        || op == `CFL_OP_LD_IR || op == `CFL_OP_BSEARCH) |=> $stable(flags[0])) else $error("carry changed");
    a_cset_forces: assert property (cmd_q && op == `CFL_OP_CSET |=> flags[0] && !flags[4] && !flags[1])
        else $error("carry force wrong");
    a_rot_clears: assert property (cmd_q && op >= `CFL_OP_RLC && op <= `CFL_OP_SRL
        |=> !flags[4] && !flags[1]) else $error("rotate flags wrong");
endmodule // cfl_flag_unit_chk

bind cfl_flag_unit cfl_flag_unit_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .flags(flags));
`default_nettype wire

// File: testbench/cpu_condition_flag_logic_tb_top.sv
// self-checking bench for the condition-flag unit, driven as an AHB-Lite master
// assumes a single slave whose hreadyout is fed back as hready
`timescale 1ns/10ps
`default_nettype none
`include "cfl_defines.vh"

module cpu_condition_flag_logic_tb_top;
    logic        hclk = 0;
    logic        hresetn = 0;
    logic        hsel = 0;
    logic [31:0] haddr = 0;
    logic [1:0]  htrans = 0;
    logic        hwrite = 0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 0;
    wire  logic  hready;
    wire  [31:0] hrdata;
    wire  [7:0]  flags;
    wire  logic  hresp;
    int          err_count = 0;
    int          samples_checked = 0;
    logic [31:0] rv;

    always #2.5 hclk = ~hclk;

    cfl_flag_unit dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
        .hresp(hresp), .hrdata(hrdata), .flags(flags));

    task automatic chk(input string nm, input [31:0] seen, input [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // hready is sampled before the edge since it only moves on rising edges
    task automatic xfer(input logic w, input [7:0] a, input [31:0] d, output [31:0] q);
        logic ok;
        @(posedge hclk);
        hsel <= 1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do begin @(negedge hclk); ok = hready; @(posedge hclk); end while (!ok);
        htrans <= 2'h0;
        hsel <= 0;
        hwdata <= d;
        do begin @(negedge hclk); ok = hready; q = hrdata; @(posedge hclk); end while (!ok);
    endtask

    task automatic op(input [7:0] pre, input [15:0] a, input [15:0] b, input [20:0] aux,
                      input [5:0] code, input [7:0] m, input [7:0] e);
        xfer(1, 8'h0C, {24'h0, pre}, rv);
        xfer(1, 8'h00, {16'h0, a}, rv);
        xfer(1, 8'h04, {16'h0, b}, rv);
        xfer(1, 8'h08, {11'h0, aux}, rv);
        xfer(1, 8'h10, {26'h0, code}, rv);
        @(negedge hclk);
        chk("flags", {24'h0, flags & m}, {24'h0, e});
    endtask

    task automatic t_reset;
        xfer(0, 8'h0C, 0, rv); chk("flags reg", rv, 32'h0);
        xfer(0, 8'h14, 0, rv); chk("result reg", rv, 32'h0);
        xfer(1, 8'h1C, 32'hFFFFFFFF, rv);
        xfer(0, 8'h1C, 0, rv); chk("unmapped", rv, 32'h0);
        hsize <= 3'h0;
        xfer(1, 8'h00, 32'h5A, rv);
        hsize <= 3'h2;
        xfer(0, 8'h00, 0, rv);
        chk("byte write", rv, 32'h0);
    endtask

    task automatic t_arith;
        op(8'hD7, 16'h7F, 16'h01, 0, `CFL_OP_ADD, 8'hD7, 8'h94);
        xfer(0, 8'h14, 0, rv); chk("add result", rv, 32'h80);
        op(8'h00, 16'hFF, 16'h01, 0, `CFL_OP_ADD, 8'hD7, 8'h51);
        op(8'h01, 16'h0F, 16'h00, 0, `CFL_OP_ADC, 8'hD7, 8'h10);
        op(8'h00, 16'h80, 16'h01, 0, `CFL_OP_SUB, 8'hD7, 8'h16);
        op(8'h01, 16'h00, 16'h00, 0, `CFL_OP_SBC, 8'hD7, 8'h93);
        op(8'h00, 16'h05, 16'h05, 0, `CFL_OP_CMP, 8'hD7, 8'h42);
        op(8'h00, 16'h01, 16'h00, 0, `CFL_OP_NEG, 8'hD7, 8'h93);
        op(8'h01, 16'h7F, 16'h00, 0, `CFL_OP_INC, 8'hD7, 8'h95);
        op(8'h00, 16'h00, 16'h00, 0, `CFL_OP_DEC, 8'hD7, 8'h92);
    endtask

    task automatic t_logic;
        op(8'hD7, 16'hF0, 16'h0F, 0, `CFL_OP_AND, 8'hD7, 8'h54);
        op(8'hD7, 16'h01, 16'h02, 0, `CFL_OP_OR, 8'hD7, 8'h04);
        op(8'hD7, 16'h80, 16'h00, 0, `CFL_OP_XOR, 8'hD7, 8'h80);
    endtask

    task automatic t_wide;
        op(8'h01, 16'h7FFF, 16'h0000, 0, `CFL_OP_ADC16, 8'hC7, 8'h84);
        op(8'h00, 16'h0000, 16'h0001, 0, `CFL_OP_SBC16, 8'hC7, 8'h83);
        op(8'hD7, 16'hFFFF, 16'h0001, 0, `CFL_OP_ADD16, 8'hD7, 8'hD5);
    endtask

    task automatic t_shift;
        op(8'hD6, 16'h81, 16'h00, 0, `CFL_OP_RLC, 8'hD7, 8'h05);
        op(8'hD6, 16'h01, 16'h00, 0, `CFL_OP_SRL, 8'hD7, 8'h45);
        op(8'hD6, 16'h80, 16'h00, 0, `CFL_OP_SRA, 8'hD7, 8'h84);
        op(8'hD7, 16'h12, 16'h34, 0, `CFL_OP_DGL, 8'hD7, 8'h01);
        xfer(0, 8'h14, 0, rv); chk("digit result", rv, 32'h4213);
        op(8'h00, 16'h12, 16'h34, 0, `CFL_OP_DGR, 8'hD7, 8'h04);
        op(8'hD6, 16'h80, 16'h00, 0, `CFL_OP_RLA, 8'hD7, 8'hC5);
    endtask

    task automatic t_block;
        op(8'h00, 16'h00, 16'h00, 21'h1, `CFL_OP_BIO, 8'h42, 8'h42);
        op(8'h00, 16'h00, 16'h00, 21'h3, `CFL_OP_BIO, 8'h42, 8'h02);
        op(8'h00, 16'h00, 16'h00, 21'h5, `CFL_OP_BIO_REP, 8'h42, 8'h42);
        op(8'hD7, 16'h00, 16'h00, 21'h2, `CFL_OP_BMOVE, 8'h16, 8'h04);
        op(8'hD7, 16'h00, 16'h00, 21'h1, `CFL_OP_BMOVE, 8'h16, 8'h00);
        op(8'hD7, 16'h00, 16'h00, 21'h5, `CFL_OP_BMOVE_REP, 8'h16, 8'h00);
        op(8'h01, 16'h55, 16'h55, 21'h2, `CFL_OP_BSEARCH, 8'h47, 8'h47);
        op(8'h00, 16'h55, 16'h54, 21'h1, `CFL_OP_BSEARCH, 8'h47, 8'h02);
    endtask

    task automatic t_misc;
        op(8'hD7, 16'h00, 16'h00, 21'h100000, `CFL_OP_LD_IR, 8'hD7, 8'h45);
        op(8'h00, 16'h80, 16'h00, 21'h0, `CFL_OP_LD_IR, 8'hD7, 8'h80);
        op(8'h01, 16'h08, 16'h00, 21'h30000, `CFL_OP_BIT, 8'h53, 8'h51);
        op(8'h02, 16'hFE, 16'h00, 21'h0, `CFL_OP_BIT, 8'h53, 8'h10);
        op(8'hC6, 16'h00, 16'h00, 0, `CFL_OP_CSET, 8'hD7, 8'hC5);
        op(8'hC5, 16'h00, 16'h00, 0, `CFL_OP_CTGL, 8'hC7, 8'hC4);
        op(8'hC4, 16'h00, 16'h00, 0, `CFL_OP_INV, 8'hD7, 8'hD6);
        op(8'h13, 16'h00, 16'h00, 0, `CFL_OP_INC_IND, 8'hD7, 8'h45);
        op(8'h00, 16'h9A, 16'h00, 0, `CFL_OP_BCD, 8'hD7, 8'h55);
        op(8'h12, 16'h0F, 16'h00, 0, `CFL_OP_BCD, 8'hD7, 8'h06);
        op(8'h55, 16'h00, 16'h00, 0, 6'h3F, 8'hD7, 8'h55);
        xfer(0, 8'h18, 0, rv);
        chk("illegal seen", rv & 32'h1, 32'h1);
        xfer(0, 8'h10, 0, rv);
        chk("last op", rv, 32'h3F);
    endtask

    task automatic conclude;
        if (err_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1;
        t_reset;
        t_arith;
        t_logic;
        t_wide;
        t_shift;
        t_block;
        t_misc;
        conclude;
    end

    // the whole sequence needs well under a thousand cycles
    initial begin
        #20000;
        err_count++;
        conclude;
    end
endmodule // cpu_condition_flag_logic_tb_top
`default_nettype wire

// File: verilog/cfl_adder.v
// parameterised adder/subtractor giving sum, carry or borrow, nibble half-carry and signed overflow
// assumes purely combinational use inside the flag unit
`timescale 1ns/10ps
`default_nettype none

module cfl_adder #(
    parameter W  = 8,                      // operand width
    parameter HB = 4                       // bit that half-carry watches
) (
    input  wire [W-1:0] a,                 // minuend or first addend
    input  wire [W-1:0] b,                 // subtrahend or second addend
    input  wire         cin,               // carry or borrow in
    input  wire         sub,               // high for subtraction
    output wire [W-1:0] sum,               // result
    output wire         carry,             // carry out, or borrow for subtraction
    output wire         half,              // carry into or borrow from bit HB
    output wire         ovf                // signed overflow
);
    wire [W-1:0] bb;
    wire         cc;
    wire [W:0]   full;

    // subtraction as a + ~b + ~borrow, so one carry chain serves both
    assign bb    = sub ? ~b : b;
    assign cc    = cin ^ sub;
    assign full  = {1'b0, a} + {1'b0, bb} + {{W{1'b0}}, cc};
    assign sum   = full[W-1:0];
    assign carry = full[W] ^ sub;
    assign half  = a[HB] ^ bb[HB] ^ sum[HB] ^ sub;
    assign ovf   = (a[W-1] == bb[W-1]) && (sum[W-1] != a[W-1]);
endmodule // cfl_adder

`default_nettype wire

// File: verilog/cfl_defines.vh
// constants of the condition-flag unit: register map, field positions, reset values, op codes
// assumes a 32-bit AHB-Lite slave decoding the low byte of haddr
`ifndef CFL_DEFINES_VH
`define CFL_DEFINES_VH

`define CFL_OFS_OPA       8'h00
`define CFL_OFS_OPB       8'h04
`define CFL_OFS_AUX       8'h08
`define CFL_OFS_FLAGS     8'h0C
`define CFL_OFS_CMD       8'h10
`define CFL_OFS_RESULT    8'h14
`define CFL_OFS_STATUS    8'h18

`define CFL_S_BIT         7
`define CFL_Z_BIT         6
`define CFL_H_BIT         4
`define CFL_PV_BIT        2
`define CFL_N_BIT         1
`define CFL_C_BIT         0
`define CFL_FLAGS_MASK    8'hD7

`define CFL_AUX_CNT_HI    15
`define CFL_AUX_BIT_HI    18
`define CFL_AUX_BIT_LO    16
`define CFL_AUX_IEL       20
`define CFL_AUX_W         21

`define CFL_FLAGS_RST     8'h00
`define CFL_WORD_RST      16'h0000
`define CFL_AUX_RST       21'h000000
`define CFL_OP_RST        6'h00

`define CFL_HSIZE_WORD    3'h2
`define CFL_READ_WAIT     1
`define CFL_ST_ILLEGAL    0

`define CFL_OP_NOP        6'h00
`define CFL_OP_ADD        6'h01
`define CFL_OP_ADC        6'h02
`define CFL_OP_SUB        6'h03
`define CFL_OP_SBC        6'h04
`define CFL_OP_CMP        6'h05
`define CFL_OP_NEG        6'h06
`define CFL_OP_AND        6'h07
`define CFL_OP_OR         6'h08
`define CFL_OP_XOR        6'h09
`define CFL_OP_INC        6'h0A
`define CFL_OP_DEC        6'h0B
`define CFL_OP_ADD16      6'h0C
`define CFL_OP_ADC16      6'h0D
`define CFL_OP_SBC16      6'h0E
`define CFL_OP_RLC        6'h0F
`define CFL_OP_RRC        6'h10
`define CFL_OP_RL         6'h11
`define CFL_OP_RR         6'h12
`define CFL_OP_SLA        6'h13
`define CFL_OP_SRA        6'h14
`define CFL_OP_SRL        6'h15
`define CFL_OP_RLCA       6'h16
`define CFL_OP_RRCA       6'h17
`define CFL_OP_RLA        6'h18
`define CFL_OP_RRA        6'h19
`define CFL_OP_DGL        6'h1A
`define CFL_OP_DGR        6'h1B
`define CFL_OP_BCD        6'h1C
`define CFL_OP_INV        6'h1D
`define CFL_OP_CSET       6'h1E
`define CFL_OP_CTGL       6'h1F
`define CFL_OP_INC_IND    6'h20
`define CFL_OP_BIO        6'h21
`define CFL_OP_BIO_REP    6'h22
`define CFL_OP_BMOVE      6'h23
`define CFL_OP_BMOVE_REP  6'h24
`define CFL_OP_BSEARCH    6'h25
`define CFL_OP_LD_IR      6'h26
`define CFL_OP_BIT        6'h27

`endif

// File: verilog/cfl_flag_unit.v
// condition-flag unit of an 8-bit processor datapath, reached as an AHB-Lite slave
// assumes one bus master, word transfers, hready wired back from hreadyout
//
// Functional notes
// - 8-bit add/adc: S Z H C from result, PV overflow, N cleared.
// - sub, sbc, compare, negate: S Z H C, PV overflow, N set.
// - logic ops: PV parity, N and C cleared; H set for and, cleared otherwise.
// - 16-bit add with carry: S Z C, PV overflow, N cleared, H undefined.
// - 16-bit subtract with borrow: S Z C, PV overflow, N set, H undefined.
// - rotates/shifts of locations: S Z C, PV parity, H and N cleared.
// - digit rotates: S Z, PV parity, H N cleared, C kept.
// - block I/O: N set, Z shows counter reached zero; S H PV undefined.
// - block moves: H N cleared; PV set if count nonzero after; repeat ends PV 0.
// - block search: Z on equal, PV while count nonzero, N set, C kept.
// - load from vector/refresh: PV takes enable latch, S Z, H N cleared, C kept.
// - bit test: tested bit into Z, H set, N cleared, C kept, PV undefined.
// - invert/force/toggle carry keep S Z PV; indirect input: S Z parity, H N cleared.
// - zero flag set when result is zero, cleared otherwise.
// - parity flag 1 for even ones count; overflow flag 1 on signed overflow.
// - half-carry on carry into or borrow from bit 4.
// - N set after subtraction; carry, bit 0, on carry out of MSB.
// - decimal adjust corrects packed BCD using H and N.
// - block I/O: zero set when counter minus one equals zero; the repeat form always sets zero.
`timescale 1ns/10ps
`default_nettype none
`include "cfl_defines.vh"

module cfl_flag_unit (
    input  wire        hclk,               // bus clock, 200 MHz
    input  wire        hresetn,            // asynchronous reset, active low
    input  wire        hsel,               // slave select
    input  wire [31:0] haddr,              // byte address
    input  wire [1:0]  htrans,             // transfer type
    input  wire        hwrite,             // write when high
    input  wire [2:0]  hsize,              // transfer size
    input  wire [31:0] hwdata,             // write data
    input  wire        hready,             // bus ready in
    output reg         hreadyout,          // slave ready
    output reg         hresp,              // response, always okay
    output reg  [31:0] hrdata,             // read data
    output reg  [7:0]  flags               // live flag byte
);
    reg         wr_pend;
    reg  [7:0]  wr_addr;
    reg         rd_pend;
    reg  [7:0]  rd_addr;
    reg  [15:0] opa;
    reg  [15:0] opb;
    reg  [20:0] aux;
    reg  [15:0] result;
    reg  [5:0]  last_op;
    reg  [15:0] exec_count;
    reg         illegal_seen;

    reg         ns;
    reg         nz;
    reg         nh;
    reg         npv;
    reg         nn;
    reg         nc;
    reg  [15:0] next_result;
    reg         illegal;
    reg  [7:0]  rot_val;
    reg         rot_c;
    reg  [7:0]  bcd_cor;
    reg  [31:0] rd_mux;

    wire        addr_ok;
    wire        wr_cmd;
    wire [5:0]  op;
    wire [7:0]  a8;
    wire        cf;
    wire [7:0]  add_a;
    wire [7:0]  add_b;
    wire        add_cin;
    wire        add_sub;
    wire [7:0]  sum8;
    wire        c8;
    wire        h8;
    wire        v8;
    wire [15:0] sum16;
    wire        c16;
    wire        v16;
    wire [7:0]  cnt8;
    wire [15:0] cnt16;
    wire [7:0]  logic_and;
    wire [7:0]  logic_or;
    wire [7:0]  logic_xor;
    wire [7:0]  digit_l;
    wire [7:0]  digit_r;
    wire [7:0]  bcd_val;
    wire        bcd_lo;
    wire        bcd_hi;

    assign addr_ok = hsel & htrans[1] & hready;
    assign wr_cmd  = wr_pend && (wr_addr == `CFL_OFS_CMD);
    assign op      = hwdata[5:0];
    assign a8      = opa[7:0];
    assign cf      = flags[`CFL_C_BIT];

    // one 8-bit chain for add, sub, compare, negate, inc/dec and search
    assign add_a   = (op == `CFL_OP_NEG) ? 8'h00 : a8;
    assign add_b   = (op == `CFL_OP_NEG) ? a8 :
                     ((op == `CFL_OP_INC) || (op == `CFL_OP_DEC)) ? 8'h01 : opb[7:0];
    assign add_cin = ((op == `CFL_OP_ADC) || (op == `CFL_OP_SBC)) ? cf : 1'b0;
    assign add_sub = (op == `CFL_OP_SUB) || (op == `CFL_OP_SBC) || (op == `CFL_OP_CMP) ||
                     (op == `CFL_OP_NEG) || (op == `CFL_OP_DEC) || (op == `CFL_OP_BSEARCH);

    cfl_adder #(.W(8), .HB(4)) u_add8 (
        .a     (add_a),
        .b     (add_b),
        .cin   (add_cin),
        .sub   (add_sub),
        .sum   (sum8),
        .carry (c8),
        .half  (h8),
        .ovf   (v8)
    );

    cfl_adder #(.W(16), .HB(12)) u_add16 (
        .a     (opa),
        .b     (opb),
        .cin   ((op == `CFL_OP_ADD16) ? 1'b0 : cf),
        .sub   (op == `CFL_OP_SBC16),
        .sum   (sum16),
        .carry (c16),
        .half  (),
        .ovf   (v16)
    );

    assign cnt8      = aux[7:0] - 8'h01;
    assign cnt16     = aux[`CFL_AUX_CNT_HI:0] - 16'h0001;
    assign logic_and = a8 & opb[7:0];
    assign logic_or  = a8 | opb[7:0];
    assign logic_xor = a8 ^ opb[7:0];
    assign digit_l   = {opb[3:0], a8[3:0]};
    assign digit_r   = {a8[3:0], opb[7:4]};

    // decimal adjust: low nibble fix from H or >9, high fix from C or >0x99
    assign bcd_lo  = flags[`CFL_H_BIT] || (a8[3:0] > 4'h9);
    assign bcd_hi  = cf || (a8 > 8'h99);
    always @* begin
        bcd_cor = {(bcd_hi ? 4'h6 : 4'h0), (bcd_lo ? 4'h6 : 4'h0)};
    end
    assign bcd_val = flags[`CFL_N_BIT] ? (a8 - bcd_cor) : (a8 + bcd_cor);

    always @* begin
        rot_val = a8;
        rot_c   = cf;
        case (op)
            `CFL_OP_RLC, `CFL_OP_RLCA: begin
                rot_val = {a8[6:0], a8[7]};
                rot_c   = a8[7];
            end
            `CFL_OP_RRC, `CFL_OP_RRCA: begin
                rot_val = {a8[0], a8[7:1]};
                rot_c   = a8[0];
            end
            `CFL_OP_RL, `CFL_OP_RLA: begin
                rot_val = {a8[6:0], cf};
                rot_c   = a8[7];
            end
            `CFL_OP_RR, `CFL_OP_RRA: begin
                rot_val = {cf, a8[7:1]};
                rot_c   = a8[0];
            end
            `CFL_OP_SLA: begin
                rot_val = {a8[6:0], 1'b0};
                rot_c   = a8[7];
            end
            `CFL_OP_SRA: begin
                rot_val = {a8[7], a8[7:1]};
                rot_c   = a8[0];
            end
            `CFL_OP_SRL: begin
                rot_val = {1'b0, a8[7:1]};
                rot_c   = a8[0];
            end
            default: begin
                rot_val = a8;
                rot_c   = cf;
            end
        endcase
    end

    // every flag starts at its held value, so undefined ones stay deterministic
    always @* begin
        ns          = flags[`CFL_S_BIT];
        nz          = flags[`CFL_Z_BIT];
        nh          = flags[`CFL_H_BIT];
        npv         = flags[`CFL_PV_BIT];
        nn          = flags[`CFL_N_BIT];
        nc          = cf;
        next_result = result;
        illegal     = 1'b0;
        case (op)
            `CFL_OP_NOP: begin
                next_result = result;
            end
            `CFL_OP_ADD, `CFL_OP_ADC, `CFL_OP_SUB, `CFL_OP_SBC, `CFL_OP_CMP, `CFL_OP_NEG: begin
                next_result = {8'h00, sum8};
                ns  = sum8[7];
                nz  = (sum8 == 8'h00);
                nh  = h8;
                npv = v8;
                nn  = add_sub;
                nc  = c8;
            end
            `CFL_OP_INC, `CFL_OP_DEC: begin
                next_result = {8'h00, sum8};
                ns  = sum8[7];
                nz  = (sum8 == 8'h00);
                nh  = h8;
                npv = v8;
                nn  = add_sub;
            end
            `CFL_OP_AND, `CFL_OP_OR, `CFL_OP_XOR: begin
                next_result = {8'h00, (op == `CFL_OP_AND) ? logic_and :
                                      (op == `CFL_OP_OR) ? logic_or : logic_xor};
                ns  = next_result[7];
                nz  = (next_result[7:0] == 8'h00);
                nh  = (op == `CFL_OP_AND);
                npv = ~^next_result[7:0];
                nn  = 1'b0;
                nc  = 1'b0;
            end
            `CFL_OP_ADD16: begin
                next_result = sum16;
                nn  = 1'b0;
                nc  = c16;
            end
            `CFL_OP_ADC16, `CFL_OP_SBC16: begin
                next_result = sum16;
                ns  = sum16[15];
                nz  = (sum16 == 16'h0000);
                npv = v16;
                nn  = (op == `CFL_OP_SBC16);
                nc  = c16;
            end
            `CFL_OP_RLC, `CFL_OP_RRC, `CFL_OP_RL, `CFL_OP_RR, `CFL_OP_SLA, `CFL_OP_SRA, `CFL_OP_SRL: begin
                next_result = {8'h00, rot_val};
                ns  = rot_val[7];
                nz  = (rot_val == 8'h00);
                npv = ~^rot_val;
                nh  = 1'b0;
                nn  = 1'b0;
                nc  = rot_c;
            end
            `CFL_OP_RLCA, `CFL_OP_RRCA, `CFL_OP_RLA, `CFL_OP_RRA: begin
                next_result = {8'h00, rot_val};
                nh  = 1'b0;
                nn  = 1'b0;
                nc  = rot_c;
            end
            `CFL_OP_DGL, `CFL_OP_DGR: begin
                next_result = (op == `CFL_OP_DGL) ? {digit_l, a8[7:4], opb[7:4]} :
                                                    {digit_r, a8[7:4], opb[3:0]};
                ns  = next_result[7];
                nz  = (next_result[7:0] == 8'h00);
                npv = ~^next_result[7:0];
                nh  = 1'b0;
                nn  = 1'b0;
            end
            `CFL_OP_BCD: begin
                next_result = {8'h00, bcd_val};
                ns  = bcd_val[7];
                nz  = (bcd_val == 8'h00);
                nh  = flags[`CFL_N_BIT] ? (flags[`CFL_H_BIT] && (a8[3:0] < 4'h6)) : (a8[3:0] > 4'h9);
                npv = ~^bcd_val;
                nc  = bcd_hi;
            end
            `CFL_OP_INV: begin
                next_result = {8'h00, ~a8};
                nh  = 1'b1;
                nn  = 1'b1;
            end
            `CFL_OP_CSET: begin
                nh  = 1'b0;
                nn  = 1'b0;
                nc  = 1'b1;
            end
            `CFL_OP_CTGL: begin
                nn  = 1'b0;
                nc  = ~cf;
            end
            `CFL_OP_INC_IND: begin
                next_result = {8'h00, a8};
                ns  = a8[7];
                nz  = (a8 == 8'h00);
                npv = ~^a8;
                nh  = 1'b0;
                nn  = 1'b0;
            end
            `CFL_OP_BIO, `CFL_OP_BIO_REP: begin
                next_result = {8'h00, cnt8};
                nz  = (op == `CFL_OP_BIO_REP) ? 1'b1 : (cnt8 == 8'h00);
                nn  = 1'b1;
            end
            `CFL_OP_BMOVE, `CFL_OP_BMOVE_REP: begin
                next_result = (op == `CFL_OP_BMOVE_REP) ? 16'h0000 : cnt16;
                npv = (op == `CFL_OP_BMOVE) && (cnt16 != 16'h0000);
                nh  = 1'b0;
                nn  = 1'b0;
            end
            `CFL_OP_BSEARCH: begin
                next_result = cnt16;
                nz  = (a8 == opb[7:0]);
                npv = (cnt16 != 16'h0000);
                nn  = 1'b1;
            end
            `CFL_OP_LD_IR: begin
                next_result = {8'h00, a8};
                ns  = a8[7];
                nz  = (a8 == 8'h00);
                npv = aux[`CFL_AUX_IEL];
                nh  = 1'b0;
                nn  = 1'b0;
            end
            `CFL_OP_BIT: begin
                nz  = a8[aux[`CFL_AUX_BIT_HI:`CFL_AUX_BIT_LO]];
                nh  = 1'b1;
                nn  = 1'b0;
            end
            default: begin
                illegal = 1'b1;
            end
        endcase
    end

    always @* begin
        case (rd_addr)
            `CFL_OFS_OPA:    rd_mux = {16'h0000, opa};
            `CFL_OFS_OPB:    rd_mux = {16'h0000, opb};
            `CFL_OFS_AUX:    rd_mux = {11'h000, aux};
            `CFL_OFS_FLAGS:  rd_mux = {24'h000000, flags};
            `CFL_OFS_CMD:    rd_mux = {26'h0000000, last_op};
            `CFL_OFS_RESULT: rd_mux = {16'h0000, result};
            `CFL_OFS_STATUS: rd_mux = {exec_count, 15'h0000, illegal_seen};
            default:         rd_mux = 32'h00000000;
        endcase
    end

    // reads take one wait state so hrdata comes from a flop and sees writes already landed
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend   <= 1'b0;
            wr_addr   <= 8'h00;
            rd_pend   <= 1'b0;
            rd_addr   <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h00000000;
        end else begin
            hresp   <= 1'b0;
            wr_pend <= addr_ok && hwrite && (hsize == `CFL_HSIZE_WORD) && (haddr[31:8] == 24'h000000);
            wr_addr <= haddr[7:0];
            if (addr_ok && !hwrite) begin
                rd_pend   <= 1'b1;
                rd_addr   <= (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hFF;
                hreadyout <= 1'b0;
            end else if (rd_pend) begin
                rd_pend   <= 1'b0;
                hrdata    <= rd_mux;
                hreadyout <= 1'b1;
            end
        end
    end

    // flags change on the very edge that takes the command word
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            opa          <= `CFL_WORD_RST;
            opb          <= `CFL_WORD_RST;
            aux          <= `CFL_AUX_RST;
            flags        <= `CFL_FLAGS_RST;
            result       <= `CFL_WORD_RST;
            last_op      <= `CFL_OP_RST;
            exec_count   <= `CFL_WORD_RST;
            illegal_seen <= 1'b0;
        end else if (wr_pend) begin
            case (wr_addr)
                `CFL_OFS_OPA:   opa   <= hwdata[15:0];
                `CFL_OFS_OPB:   opb   <= hwdata[15:0];
                `CFL_OFS_AUX:   aux   <= hwdata[20:0];
                `CFL_OFS_FLAGS: flags <= hwdata[7:0] & `CFL_FLAGS_MASK;
                `CFL_OFS_STATUS: begin
                    if (hwdata[`CFL_ST_ILLEGAL]) begin
                        illegal_seen <= 1'b0;
                    end
                end
                default: begin
                    opa <= opa;
                end
            endcase
            if (wr_cmd) begin
                flags      <= {ns, nz, 1'b0, nh, 1'b0, npv, nn, nc};
                result     <= next_result;
                last_op    <= op;
                exec_count <= exec_count + 16'h0001;
                if (illegal) begin
                    illegal_seen <= 1'b1;
                end
            end
        end
    end
endmodule // cfl_flag_unit

`default_nettype wire
